// [include/adc_calc_consts.vh]
// Constants for the converter result computation block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
`ifndef ADC_CALC_CONSTS_VH
`define ADC_CALC_CONSTS_VH

// Register byte offsets.
`define OFS_CTRL0 5'h00
`define OFS_CONFIG 5'h04
`define OFS_REPEAT 5'h08
`define OFS_STATUS 5'h0C
`define OFS_SUM 5'h10
`define OFS_FILTER 5'h14
`define OFS_RESULT 5'h18

// Control register 0 fields.
`define CTRL_ON_BIT 7
`define CTRL_REARM_BIT 6
`define CTRL_CLKSRC_BIT 4
`define CTRL_JUSTIFY_BIT 2
`define CTRL_GO_BIT 0

// Configuration register fields.
`define CFG_MODE_LSB 0
`define CFG_DSEN_BIT 3
`define CFG_CLEAR_BIT 4
`define CFG_STOP_IRQ_BIT 5
`define CFG_SHIFT_LSB 8

// Status register fields.
`define STAT_TALLY_LSB 0
`define STAT_WRAP_BIT 8
`define STAT_IRQ_BIT 9

// Computation modes.
`define MODE_BASIC 3'h0
`define MODE_ACCUM 3'h1
`define MODE_AVERAGE 3'h2
`define MODE_BURST 3'h3
`define MODE_LOWPASS 3'h4

// Reset values and limits.
`define TALLY_MAX 8'hFF
`define RESET_REPEAT 8'h00
`define RESET_CTRL0 8'h00

`endif

// [logic/adc_calc_unit.v]
// Combinational update of running sum and sample tally for one trigger.
// Assumes the caller has already applied any clear to sum_i and tally_i.
`timescale 1ns/100ps
`include "adc_calc_consts.vh"

module adc_calc_unit #(
  parameter RES_W = 12,
  parameter SUM_W = 18
) (
  input wire [2:0] mode_i,
  input wire dsen_i,
  input wire [RES_W-1:0] cur_i,
  input wire [RES_W-1:0] prev_i,
  input wire signed [SUM_W-1:0] sum_i,
  input wire [7:0] tally_i,
  input wire [2:0] shift_i,
  output reg signed [SUM_W-1:0] sum_o,
  output reg [7:0] tally_o,
  output reg wrap_o,
  output wire signed [SUM_W-1:0] filt_o
);
  wire signed [SUM_W:0] cur_x = $signed({{(SUM_W+1-RES_W){1'b0}}, cur_i});
  wire signed [SUM_W:0] prev_x = $signed({{(SUM_W+1-RES_W){1'b0}}, prev_i});
  // Double-sample mode takes current minus previous result.
  wire signed [SUM_W:0] sample = dsen_i ? (cur_x - prev_x) : cur_x;
  wire signed [SUM_W:0] sum_x = {sum_i[SUM_W-1], sum_i};
  wire signed [SUM_W:0] decay = sum_x >>> shift_i;
  wire [7:0] tally_sat = (tally_i == `TALLY_MAX) ? tally_i : tally_i + 8'h01;
  reg signed [SUM_W:0] wide;

  always @* begin
    wide = sum_x;
    sum_o = sum_i;
    tally_o = tally_i;
    wrap_o = 1'b0;
    case (mode_i)
      `MODE_ACCUM, `MODE_AVERAGE, `MODE_BURST: begin
        wide = sum_x + sample;
        tally_o = tally_sat;
      end
      `MODE_LOWPASS: begin
        wide = sum_x + sample - decay;
        tally_o = tally_sat;
      end
      default: begin
        wide = sum_x;
      end
    endcase
    if (mode_i != `MODE_BASIC && mode_i <= `MODE_LOWPASS) begin
      sum_o = wide[SUM_W-1:0];
      wrap_o = wide[SUM_W] ^ wide[SUM_W-1];
    end
  end

  assign filt_o = sum_o >>> shift_i;
endmodule // adc_calc_unit

// [logic/adc_result_computation.v]
// Converter result computation unit with its control registers on Avalon-MM.
// Assumes the analog converter outside raises conv_done_i for one cycle with a result
// while conv_req_o is high, and supplies the threshold comparison on threshold_true_i.
//
// How it works
// - Basic mode leaves sum and tally alone, only a clear zeroes them, every sample is tested.
// - Accumulate, average and burst modes add the sample and count the tally up to 0xFF.
// - The sample is the current result, or the current minus the previous one in double-sample mode.
// - Average mode clears on request or when a cycle starts with the tally at or above target.
// - Burst mode clears on request or at each start, then repeats while below target.
// - Low-pass mode sets sum to sample plus sum minus shifted sum and saturates the tally.
// - The filtered output is the sum shifted right, and the wrap flag shows sum overflow.
// - Control register 0 holds enable, rearm, clock source, justify and start; gaps read zero.
// - Auto-rearm restarts each trigger until the flag stops it or software clears start.
// - Writing start begins a cycle, start reads one while busy, and it needs the enable set.
// - The clock source bit picks the dedicated oscillator at one, the divided clock at zero.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_calc_consts.vh"

module adc_result_computation #(
  parameter RES_W = 12,
  parameter SUM_W = 18
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output wire conv_req_o,
  input wire conv_done_i,
  input wire [RES_W-1:0] conv_result_i,
  input wire threshold_true_i,
  output wire dedicated_rc_osc_o,
  output wire result_justify_o,
  output wire threshold_irq_flag_o,
  output reg [SUM_W-1:0] filtered_output_o
);
  reg on_q;
  reg rearm_q;
  reg clksrc_q;
  reg justify_q;
  reg go_q;
  reg go_d;
  reg [2:0] mode_q;
  reg dsen_q;
  reg stop_irq_q;
  reg [2:0] shift_q;
  reg [7:0] repeat_q;
  reg signed [SUM_W-1:0] sum_q;
  reg signed [SUM_W-1:0] sum_d;
  reg [7:0] tally_q;
  reg [7:0] tally_d;
  reg wrap_q;
  reg wrap_d;
  reg irq_q;
  reg irq_d;
  reg new_cycle_q;
  reg new_cycle_d;
  reg [RES_W-1:0] prev_q;
  reg [RES_W-1:0] result_q;
  reg ack_q;
  reg signed [SUM_W-1:0] base_sum;
  reg [7:0] base_tally;
  reg test_en;
  reg rearm_now;

  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ack_q;
  wire [2:0] idx = avs_address_i[4:2];
  wire done = conv_done_i & go_q;
  wire signed [SUM_W-1:0] calc_sum;
  wire [7:0] calc_tally;
  wire calc_wrap;
  wire signed [SUM_W-1:0] calc_filt;

  // Decodes a byte offset into a register select.
  function is_reg;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      is_reg = (addr[4:2] == ofs[4:2]);
    end
  endfunction

  wire sum_clear = wr_go && is_reg(avs_address_i, `OFS_CONFIG) && avs_byteenable_i[0] &&
    avs_writedata_i[`CFG_CLEAR_BIT];

  assign avs_waitrequest_o = req & ~ack_q;
  assign conv_req_o = go_q;
  assign dedicated_rc_osc_o = clksrc_q;
  assign result_justify_o = justify_q;
  assign threshold_irq_flag_o = irq_q;

  adc_calc_unit #(
    .RES_W(RES_W),
    .SUM_W(SUM_W)
  ) u_calc (
    .mode_i(mode_q),
    .dsen_i(dsen_q),
    .cur_i(conv_result_i),
    .prev_i(prev_q),
    .sum_i(base_sum),
    .tally_i(base_tally),
    .shift_i(shift_q),
    .sum_o(calc_sum),
    .tally_o(calc_tally),
    .wrap_o(calc_wrap),
    .filt_o(calc_filt)
  );

  // Clear conditions are applied to the base values before the new sample is added,
  // so a clear arriving with a trigger is not lost.
  always @* begin
    base_sum = sum_q;
    base_tally = tally_q;
    if (sum_clear) begin
      base_sum = {SUM_W{1'b0}};
      base_tally = 8'h00;
    end else if (done && new_cycle_q) begin
      if (mode_q == `MODE_BURST) begin
        base_sum = {SUM_W{1'b0}};
        base_tally = 8'h00;
      end else if (mode_q == `MODE_AVERAGE && tally_q >= repeat_q) begin
        base_sum = {SUM_W{1'b0}};
        base_tally = 8'h00;
      end
    end
  end

  always @* begin
    sum_d = base_sum;
    tally_d = base_tally;
    wrap_d = sum_clear ? 1'b0 : wrap_q;
    irq_d = irq_q;
    go_d = go_q;
    new_cycle_d = new_cycle_q;
    rearm_now = 1'b0;
    test_en = 1'b0;
    if (wr_go && is_reg(avs_address_i, `OFS_STATUS) && avs_byteenable_i[1] &&
        avs_writedata_i[`STAT_IRQ_BIT]) begin
      irq_d = 1'b0;
    end
    if (done) begin
      sum_d = calc_sum;
      tally_d = calc_tally;
      if (calc_wrap) begin
        wrap_d = 1'b1;
      end
      new_cycle_d = 1'b0;
      if (mode_q == `MODE_BASIC || mode_q == `MODE_ACCUM || mode_q > `MODE_LOWPASS) begin
        test_en = 1'b1;
      end else begin
        test_en = (calc_tally >= repeat_q);
      end
      if (test_en && threshold_true_i) begin
        irq_d = 1'b1;
      end
      if (mode_q == `MODE_BURST && calc_tally < repeat_q) begin
        go_d = 1'b1;
      end else begin
        // Burst ends here with the whole sum held and the tally at target.
        rearm_now = rearm_q && !(stop_irq_q && irq_d);
        go_d = rearm_now;
        new_cycle_d = rearm_now;
      end
    end
    if (wr_go && is_reg(avs_address_i, `OFS_CTRL0) && avs_byteenable_i[0]) begin
      if (!avs_writedata_i[`CTRL_ON_BIT] || !avs_writedata_i[`CTRL_GO_BIT]) begin
        go_d = 1'b0;
      end else if (!go_q) begin
        go_d = 1'b1;
        new_cycle_d = 1'b1;
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      on_q <= 1'b0;
      rearm_q <= 1'b0;
      clksrc_q <= 1'b0;
      justify_q <= 1'b0;
      go_q <= 1'b0;
      mode_q <= `MODE_BASIC;
      dsen_q <= 1'b0;
      stop_irq_q <= 1'b0;
      shift_q <= 3'h0;
      repeat_q <= `RESET_REPEAT;
      sum_q <= {SUM_W{1'b0}};
      tally_q <= 8'h00;
      wrap_q <= 1'b0;
      irq_q <= 1'b0;
      new_cycle_q <= 1'b0;
      prev_q <= {RES_W{1'b0}};
      result_q <= {RES_W{1'b0}};
      filtered_output_o <= {SUM_W{1'b0}};
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      go_q <= go_d;
      sum_q <= sum_d;
      tally_q <= tally_d;
      wrap_q <= wrap_d;
      irq_q <= irq_d;
      new_cycle_q <= new_cycle_d;
      if (done) begin
        prev_q <= conv_result_i;
        result_q <= conv_result_i;
        filtered_output_o <= calc_filt;
      end
      if (wr_go && avs_byteenable_i[0]) begin
        if (is_reg(avs_address_i, `OFS_CTRL0)) begin
          on_q <= avs_writedata_i[`CTRL_ON_BIT];
          rearm_q <= avs_writedata_i[`CTRL_REARM_BIT];
          clksrc_q <= avs_writedata_i[`CTRL_CLKSRC_BIT];
          justify_q <= avs_writedata_i[`CTRL_JUSTIFY_BIT];
        end
        if (is_reg(avs_address_i, `OFS_CONFIG)) begin
          mode_q <= avs_writedata_i[`CFG_MODE_LSB +: 3];
          dsen_q <= avs_writedata_i[`CFG_DSEN_BIT];
          stop_irq_q <= avs_writedata_i[`CFG_STOP_IRQ_BIT];
        end
        if (is_reg(avs_address_i, `OFS_REPEAT)) begin
          repeat_q <= avs_writedata_i[7:0];
        end
      end
      if (wr_go && avs_byteenable_i[1] && is_reg(avs_address_i, `OFS_CONFIG)) begin
        shift_q <= avs_writedata_i[`CFG_SHIFT_LSB +: 3];
      end
      if (avs_read_i && !ack_q) begin
        avs_readdata_o <= 32'h0000_0000;
        case (idx)
          3'h0: begin
            avs_readdata_o[`CTRL_ON_BIT] <= on_q;
            avs_readdata_o[`CTRL_REARM_BIT] <= rearm_q;
            avs_readdata_o[`CTRL_CLKSRC_BIT] <= clksrc_q;
            avs_readdata_o[`CTRL_JUSTIFY_BIT] <= justify_q;
            avs_readdata_o[`CTRL_GO_BIT] <= go_q;
          end
          3'h1: begin
            avs_readdata_o[`CFG_MODE_LSB +: 3] <= mode_q;
            avs_readdata_o[`CFG_DSEN_BIT] <= dsen_q;
            avs_readdata_o[`CFG_STOP_IRQ_BIT] <= stop_irq_q;
            avs_readdata_o[`CFG_SHIFT_LSB +: 3] <= shift_q;
          end
          3'h2: begin
            avs_readdata_o[7:0] <= repeat_q;
          end
          3'h3: begin
            avs_readdata_o[`STAT_TALLY_LSB +: 8] <= tally_q;
            avs_readdata_o[`STAT_WRAP_BIT] <= wrap_q;
            avs_readdata_o[`STAT_IRQ_BIT] <= irq_q;
          end
          3'h4: begin
            avs_readdata_o[SUM_W-1:0] <= sum_q;
          end
          3'h5: begin
            avs_readdata_o[SUM_W-1:0] <= filtered_output_o;
          end
          3'h6: begin
            // Left justification places the result at the top of a 16-bit field.
            if (justify_q) begin
              avs_readdata_o[15:16-RES_W] <= result_q;
            end else begin
              avs_readdata_o[RES_W-1:0] <= result_q;
            end
          end
          default: begin
            avs_readdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule // adc_result_computation

// [dv/adc_result_computation_assertions.sv]
// Port-level checks for the computation unit.
// Assumes it is bound to the top module with matching parameters.
`timescale 1ns/100ps
module adc_result_computation_assertions #(
  parameter RES_W = 12,
  parameter SUM_W = 18
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire conv_req_o,
  input wire conv_done_i,
  input wire [RES_W-1:0] conv_result_i,
  input wire threshold_true_i,
  input wire dedicated_rc_osc_o,
  input wire result_justify_o,
  input wire threshold_irq_flag_o,
  input wire [SUM_W-1:0] filtered_output_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire req_w = avs_read_i | avs_write_i;
  wire ctl_w = avs_write_i & ~avs_waitrequest_o & (avs_address_i[4:2] == 3'h0);
  reg conv_q;
  reg hit_q;
  reg ctl_q;
  reg go_q;
  always @(posedge ref_clk_i) begin
    conv_q <= conv_done_i & conv_req_o;
    hit_q <= conv_done_i & conv_req_o & threshold_true_i;
    ctl_q <= ctl_w;
    go_q <= ctl_w & avs_writedata_i[7] & avs_writedata_i[0];
  end
  sequence s_ack;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  property p_one_wait;
    $rose(req_w) |-> s_ack;
  endproperty
  property p_idle;
    !req_w |-> !avs_waitrequest_o;
  endproperty
  property p_ignored;
    conv_done_i && !conv_req_o |=> $stable(filtered_output_o);
  endproperty
  property p_flag_cause;
    $rose(threshold_irq_flag_o) |-> hit_q;
  endproperty
  property p_flag_sticky;
    threshold_irq_flag_o && !avs_write_i |=> threshold_irq_flag_o;
  endproperty
  property p_go_cause;
    $rose(conv_req_o) |-> go_q;
  endproperty
  property p_filter_cause;
    $changed(filtered_output_o) |-> conv_q;
  endproperty
  property p_src_cause;
    $changed(dedicated_rc_osc_o) || $changed(result_justify_o) |-> ctl_q;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  a_ignored: assert property (p_ignored) else $error("idle result accepted");
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without cause");
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
  a_go_cause: assert property (p_go_cause) else $error("cycle began unasked");
  a_filter_cause: assert property (p_filter_cause) else $error("filter moved");
  a_src_cause: assert property (p_src_cause) else $error("control bit moved");
endmodule // adc_result_computation_assertions

bind adc_result_computation adc_result_computation_assertions #(
  .RES_W(RES_W),
  .SUM_W(SUM_W)
) u_chk (.*);

// [dv/adc_result_computation_test.sv]
// Self-checking bench for the computation unit.
// Drives the register bus and the conversion link directly.
`timescale 1ns/100ps
`include "adc_calc_consts.vh"
module adc_result_computation_test;
  logic clk = 0;
  logic rst = 1;
  logic rd_s = 0;
  logic wr_s = 0;
  logic dn = 0;
  logic thr = 1;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0;
  logic [31:0] q;
  logic [11:0] res = 0;
  logic [31:0] rdat;
  logic wt, req, osc, jus, flg;
  logic [17:0] flt;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  adc_result_computation i_dut (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .conv_req_o(req), .conv_done_i(dn),
    .conv_result_i(res), .threshold_true_i(thr), .dedicated_rc_osc_o(osc),
    .result_justify_o(jus), .threshold_irq_flag_o(flg), .filtered_output_o(flt));
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      finish_test;
    end
  end
  task automatic ck(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request stands until waitrequest is seen low at an edge.
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr_s <= 0;
    rd_s <= 0;
    @(posedge clk);
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    bus(1, a, d);
  endtask
  // One result pulse, whether or not a cycle is requested.
  task automatic dv(logic [11:0] v);
    res <= v;
    dn <= 1;
    @(posedge clk);
    dn <= 0;
    @(posedge clk);
  endtask
  task automatic cv(logic [11:0] v);
    while (req !== 1'b1) @(posedge clk);
    dv(v);
  endtask
  task automatic sv(logic [7:0] t, logic [17:0] s);
    bus(0, `OFS_STATUS, 0);
    ck("tally", t, q[7:0]);
    bus(0, `OFS_SUM, 0);
    ck("sum", s, q[17:0]);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, `OFS_CTRL0, 0);
    ck("ctrl0 reset", 0, q);
    bus(0, 5'h1C, 0);
    ck("unmapped", 0, q);
    wr(`OFS_CTRL0, 32'h01);
    ck("start off", 0, req);
    wr(`OFS_CTRL0, 32'hFE);
    bus(0, `OFS_CTRL0, 0);
    ck("ctrl0", 32'hD4, q);
    ck("clksrc", 1, osc);
    ck("justify", 1, jus);
    wr(`OFS_CTRL0, 0);
    ck("clksrc", 0, osc);
    $display("registers done");
    wr(`OFS_CONFIG, 32'h10);
    thr <= 0;
    wr(`OFS_CTRL0, 32'h81);
    cv(100);
    ck("flag on false test", 0, flg);
    thr <= 1;
    wr(`OFS_CTRL0, 32'h81);
    cv(100);
    sv(0, 0);
    ck("flag", 1, flg);
    ck("start", 0, req);
    dv(12'h3E7);
    bus(0, `OFS_RESULT, 0);
    ck("ignored result", 32'h64, q);
    $display("basic done");
    wr(`OFS_CONFIG, 32'h11);
    wr(`OFS_CTRL0, 32'hC1);
    cv(100);
    cv(50);
    sv(2, 150);
    wr(`OFS_CONFIG, 32'h09);
    cv(80);
    sv(3, 180);
    ck("rearm", 1, req);
    bus(0, `OFS_CTRL0, 0);
    ck("ctrl0 busy", 32'hC1, q);
    wr(`OFS_CONFIG, 32'h11);
    repeat (256) cv(1);
    sv(8'hFF, 256);
    wr(`OFS_CONFIG, 32'h11);
    repeat (33) cv(12'hFFF);
    bus(0, `OFS_STATUS, 0);
    ck("wrap status", 32'h321, q);
    wr(`OFS_CONFIG, 32'h11);
    bus(0, `OFS_STATUS, 0);
    ck("wrap cleared", 32'h200, q);
    wr(`OFS_STATUS, 32'h200);
    wr(`OFS_CONFIG, 32'h31);
    cv(5);
    ck("stop on flag", 0, req);
    $display("accumulate done");
    wr(`OFS_REPEAT, 2);
    wr(`OFS_STATUS, 32'h200);
    wr(`OFS_CONFIG, 32'h12);
    wr(`OFS_CTRL0, 32'h81);
    cv(8);
    ck("flag", 0, flg);
    wr(`OFS_CTRL0, 32'h81);
    cv(4);
    sv(2, 12);
    ck("flag", 1, flg);
    wr(`OFS_CTRL0, 32'h81);
    cv(6);
    sv(1, 6);
    $display("average done");
    wr(`OFS_REPEAT, 4);
    wr(`OFS_CONFIG, 32'h213);
    bus(0, `OFS_CONFIG, 0);
    ck("config", 32'h203, q);
    wr(`OFS_CTRL0, 32'h81);
    repeat (4) cv(10);
    sv(4, 40);
    ck("filter", 10, flt);
    ck("burst end", 0, req);
    wr(`OFS_CTRL0, 32'h81);
    cv(5);
    sv(1, 5);
    $display("burst done");
    wr(`OFS_CONFIG, 32'h114);
    wr(`OFS_CTRL0, 32'hC1);
    cv(100);
    cv(100);
    sv(2, 150);
    ck("filter", 75, flt);
    bus(0, `OFS_FILTER, 0);
    ck("filter reg", 75, q);
    wr(`OFS_CTRL0, 32'h04);
    bus(0, `OFS_RESULT, 0);
    ck("left justified", 32'h640, q);
    $display("lowpass done");
    finish_test;
  end
endmodule // adc_result_computation_test
